// [verilog/tws_map.svh]
// register offsets, field positions, reset values and counts of the three-wire serial port
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

`define TWS_ADDR_MODE   16'hFF88
`define TWS_ADDR_CSEL   16'hFF89
`define TWS_ADDR_TXB    16'hFF8A
`define TWS_ADDR_SIO    16'hFF8B

`define TWS_MODE_EN     7
`define TWS_MODE_TRMD   6
`define TWS_MODE_SSE    5
`define TWS_MODE_DIR    4
`define TWS_CSEL_CKP    4
`define TWS_CSEL_DAP    3
`define TWS_CSEL_CKS_HI 2
`define TWS_CSEL_CKS_LO 0

`define TWS_BIT_RST     1'h0
`define TWS_CKS_RST     3'h0
`define TWS_BYTE_RST    8'h00
`define TWS_PAD3        3'h0
`define TWS_CKS_EXT     3'h7
`define TWS_BITS_RST    4'h0
`define TWS_BITS_ONE    4'h1
`define TWS_LAST_BIT    4'h7
`define TWS_CNT_RST     7'h00
`define TWS_CNT_ONE     7'h01
`define TWS_SYNC_RST    3'h7

`endif

// [verilog/tws_pkg.sv]
// types shared by the three-wire serial port
package tws_pkg;

  typedef enum logic [2:0]
  {
    tws_st_idle  = 3'h1,
    tws_st_lead  = 3'h2,
    tws_st_trail = 3'h4
  } tws_state_t;

endpackage : tws_pkg

// [verilog/tws_port.sv]
// three-wire clocked serial port: mode and clock registers, shift engine, clock divider
//
// Contract
// - 8-bit mode register, reset to zero
// - enable low clears busy and shift register
// - receive-only mode holds serial output low
// - receive-only: shift register read starts reception
// - slave-select input gates transfers when used
// - bit order: zero msb first, one lsb
// - busy readable at mode bit zero
// - clock register: polarity, phase, source field
// - type index from polarity and phase
// - master clock: peripheral clock over 2^(n+1)
// - source code seven: slave, external clock
// - buffer write starts transmit and receive
// - slave with select: start only when low
// - 8-bit shift register serializes both ways
`timescale 1ns/1ps
`include "tws_map.svh"

module tws_port
  import tws_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        si_in,
  output logic             so_out,
  input  wire logic        ssi_n_in
);

  function automatic logic tws_hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction : tws_hit

  // bit that leaves the shift register next
  function automatic logic tws_first(input logic [7:0] s, input logic lsb_first);
    return lsb_first ? s[0] : s[7];
  endfunction : tws_first

  function automatic logic [7:0] tws_shift(input logic [7:0] s, input logic lsb_first, input logic b);
    return lsb_first ? {b, s[7:1]} : {s[6:0], b};
  endfunction : tws_shift

  // half period in peripheral clocks minus one: 2^n - 1
  function automatic logic [6:0] tws_limit(input logic [2:0] n);
    return (`TWS_CNT_ONE << n) - `TWS_CNT_ONE;
  endfunction : tws_limit

  // pin synchronisers: index 2 sck, 1 si, 0 slave select (active low)
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       sck_s3;
  logic [2:0] next_sync1;
  logic [2:0] next_sync2;
  logic       next_sck_s3;

  always_comb
  begin
    next_sync1  = {sck_in, si_in, ssi_n_in};
    next_sync2  = sync1;
    next_sck_s3 = sync2[2];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1  <= `TWS_SYNC_RST;
      sync2  <= `TWS_SYNC_RST;
      sck_s3 <= !`TWS_BIT_RST; // same as the synchroniser's reset, so no false edge follows reset
    end
    else
    begin
      sync1  <= next_sync1;
      sync2  <= next_sync2;
      sck_s3 <= next_sck_s3;
    end
  end

  logic sck_s2;
  logic si_s2;
  logic ssi_n_s2;
  assign sck_s2   = sync2[2];
  assign si_s2    = sync2[1];
  assign ssi_n_s2 = sync2[0];

  // control registers
  logic       en;
  logic       trmd;
  logic       sse;
  logic       dir;
  logic       ckp;
  logic       dap;
  logic [2:0] cks;
  logic [7:0] txb;
  logic       next_en;
  logic       next_trmd;
  logic       next_sse;
  logic       next_dir;
  logic       next_ckp;
  logic       next_dap;
  logic [2:0] next_cks;
  logic [7:0] next_txb;

  logic wr_mode;
  logic wr_csel;
  logic wr_txb;
  logic rd_sio;
  assign wr_mode = wr_en && tws_hit(addr, `TWS_ADDR_MODE);
  assign wr_csel = wr_en && tws_hit(addr, `TWS_ADDR_CSEL);
  assign wr_txb  = wr_en && tws_hit(addr, `TWS_ADDR_TXB);
  assign rd_sio  = rd_en && tws_hit(addr, `TWS_ADDR_SIO);

  always_comb
  begin
    next_en   = en;
    next_trmd = trmd;
    next_sse  = sse;
    next_dir  = dir;
    next_ckp  = ckp;
    next_dap  = dap;
    next_cks  = cks;
    next_txb  = txb;
    // busy bit and bits 3..1 are not writable
    if (wr_mode)
    begin
      next_en   = wdata[`TWS_MODE_EN];
      next_trmd = wdata[`TWS_MODE_TRMD];
      next_sse  = wdata[`TWS_MODE_SSE];
      next_dir  = wdata[`TWS_MODE_DIR];
    end
    // upper three bits are fixed at zero by simply not storing them
    if (wr_csel)
    begin
      next_ckp = wdata[`TWS_CSEL_CKP];
      next_dap = wdata[`TWS_CSEL_DAP];
      next_cks = wdata[`TWS_CSEL_CKS_HI:`TWS_CSEL_CKS_LO];
    end
    if (wr_txb)
      next_txb = wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en   <= `TWS_BIT_RST;
      trmd <= `TWS_BIT_RST;
      sse  <= `TWS_BIT_RST;
      dir  <= `TWS_BIT_RST;
      ckp  <= `TWS_BIT_RST;
      dap  <= `TWS_BIT_RST;
      cks  <= `TWS_CKS_RST;
      txb  <= `TWS_BYTE_RST;
    end
    else
    begin
      en   <= next_en;
      trmd <= next_trmd;
      sse  <= next_sse;
      dir  <= next_dir;
      ckp  <= next_ckp;
      dap  <= next_dap;
      cks  <= next_cks;
      txb  <= next_txb;
    end
  end

  // transfer engine
  tws_state_t state;
  logic [3:0] bits;
  logic [7:0] sreg;
  logic       so_q;
  logic [6:0] cnt;
  logic       sck_q;
  tws_state_t next_state;
  logic [3:0] next_bits;
  logic [7:0] next_sreg;
  logic       next_so_q;
  logic [6:0] next_cnt;
  logic       next_sck_q;
  logic       slave;
  logic       ssi_ok;
  logic       idle_lvl;
  logic       busy;
  logic       tick;
  logic       sck_chg;
  logic       lead_ev;
  logic       trail_ev;
  logic       start;
  logic [7:0] load;

  assign slave    = (cks == `TWS_CKS_EXT);
  assign ssi_ok   = !sse || !ssi_n_s2;
  // polarity zero idles the clock high, so types 1 and 2 start with a falling edge
  assign idle_lvl = !ckp;
  assign busy     = (state != tws_st_idle);
  assign tick     = busy && !slave && (cnt == tws_limit(cks));
  assign sck_chg  = slave && ssi_ok && (sck_s2 != sck_s3);
  assign lead_ev  = (state == tws_st_lead) && (slave ? (sck_chg && (sck_s2 != idle_lvl)) : tick);
  assign trail_ev = (state == tws_st_trail) && (slave ? (sck_chg && (sck_s2 == idle_lvl)) : tick);
  assign start    = !busy && en && ssi_ok && (trmd ? wr_txb : rd_sio);
  assign load     = trmd ? wdata : sreg;

  always_comb
  begin
    next_state = state;
    next_bits  = bits;
    next_sreg  = sreg;
    next_so_q  = so_q;
    next_cnt   = busy && !tick ? cnt + `TWS_CNT_ONE : `TWS_CNT_RST;
    next_sck_q = !busy ? idle_lvl : (tick ? !sck_q : sck_q);
    if (!en)
    begin
      // disabling aborts any byte in flight
      next_state = tws_st_idle;
      next_bits  = `TWS_BITS_RST;
      next_sreg  = `TWS_BYTE_RST;
      next_so_q  = `TWS_BIT_RST;
    end
    else
    begin
      case (state)
        tws_st_idle:
        begin
          if (start)
          begin
            next_state = tws_st_lead;
            next_bits  = `TWS_BITS_RST;
            next_sreg  = load;
            // phase one puts the first bit out before the first edge
            if (dap)
            begin
              next_so_q = tws_first(load, dir);
            end
          end
        end
        tws_st_lead:
        begin
          if (lead_ev)
          begin
            next_state = tws_st_trail;
            if (dap)
              next_sreg = tws_shift(sreg, dir, si_s2);
            else
              next_so_q = tws_first(sreg, dir);
          end
        end
        tws_st_trail:
        begin
          if (trail_ev)
          begin
            if (dap)
            begin
              if (bits != `TWS_LAST_BIT)
              begin
                next_so_q = tws_first(sreg, dir);
              end
            end
            else
            begin
              next_sreg = tws_shift(sreg, dir, si_s2);
            end
            if (bits == `TWS_LAST_BIT)
            begin
              next_state = tws_st_idle;
              next_bits  = `TWS_BITS_RST;
            end
            else
            begin
              next_state = tws_st_lead;
              next_bits  = bits + `TWS_BITS_ONE;
            end
          end
        end
        default:
        begin
          next_state = tws_st_idle;
          next_bits  = `TWS_BITS_RST;
        end
      endcase
      // receive-only output stays low whatever the engine holds
      if (!trmd)
      begin
        next_so_q = `TWS_BIT_RST;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= tws_st_idle;
      bits  <= `TWS_BITS_RST;
      sreg  <= `TWS_BYTE_RST;
      so_q  <= `TWS_BIT_RST;
      cnt   <= `TWS_CNT_RST;
      // reset value is idle-high, matching type 1
      sck_q <= !`TWS_BIT_RST;
    end
    else
    begin
      state <= next_state;
      bits  <= next_bits;
      sreg  <= next_sreg;
      so_q  <= next_so_q;
      cnt   <= next_cnt;
      sck_q <= next_sck_q;
    end
  end

  // pins: clock is driven only as master; released while disabled so the port pin is free
  assign sck_out = sck_q;
  assign sck_oe  = en && !slave;
  assign so_out  = so_q;

  // read data stands for exactly one cycle after the strobe
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = `TWS_BYTE_RST;
    if (rd_en)
    begin
      if (tws_hit(addr, `TWS_ADDR_MODE))
        next_rdata = {en, trmd, sse, dir, `TWS_PAD3, busy};
      else if (tws_hit(addr, `TWS_ADDR_CSEL))
        next_rdata = {`TWS_PAD3, ckp, dap, cks};
      else if (tws_hit(addr, `TWS_ADDR_TXB))
        next_rdata = txb;
      else if (tws_hit(addr, `TWS_ADDR_SIO))
        next_rdata = sreg;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= `TWS_BYTE_RST;
    else
      rdata <= next_rdata;
  end

endmodule : tws_port

// [testbench/tws_port_chk.sv]
// checker: port-level relations of the three-wire serial port
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_port_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rdata,
  input wire logic        sck_out,
  input wire logic        sck_oe,
  input wire logic        so_out
);
  logic [7:0] md;
  logic [7:0] cs;
  logic [7:0] next_md;
  logic [7:0] next_cs;
  always_comb
  begin
    next_md = md;
    next_cs = cs;
    if (wr_en && addr == `TWS_ADDR_MODE) next_md = wdata;
    if (wr_en && addr == `TWS_ADDR_CSEL) next_cs = wdata;
  end
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      md <= 8'h00;
      cs <= 8'h00;
    end
    else
    begin
      md <= next_md;
      cs <= next_cs;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !rd_en |=> rdata == 8'h00; endproperty
  property p_md_rd; rd_en && addr == `TWS_ADDR_MODE |=> rdata[7:4] == md[7:4]; endproperty
  property p_md_pad; rd_en && addr == `TWS_ADDR_MODE |=> rdata[3:1] == 3'h0; endproperty
  property p_cs_rd; rd_en && addr == `TWS_ADDR_CSEL |=> rdata == {3'h0, cs[4:0]}; endproperty
  property p_oe; sck_oe == (md[7] && cs[2:0] != 3'h7); endproperty
  property p_so_rx; (md[7] && !md[6]) [*2] |-> !so_out; endproperty
  property p_so_off; (!md[7]) [*2] |-> !so_out; endproperty
  property p_idle; $rose(sck_oe) |-> sck_out == !cs[4]; endproperty
  // a leading fall at divider code 2 must be followed by exactly three more low cycles
  property p_half; $fell(sck_out) && sck_oe && cs[4:0] == 5'h02 |=> !sck_out [*3] ##1 sck_out; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not cleared");
  a_md_rd: assert property (p_md_rd) else $error("mode readback wrong");
  a_md_pad: assert property (p_md_pad) else $error("mode pad bits set");
  a_cs_rd: assert property (p_cs_rd) else $error("clock select readback wrong");
  a_oe: assert property (p_oe) else $error("clock drive enable wrong");
  a_so_rx: assert property (p_so_rx) else $error("output not low in receive mode");
  a_so_off: assert property (p_so_off) else $error("output not low when disabled");
  a_idle: assert property (p_idle) else $error("clock idle level wrong");
  a_half: assert property (p_half) else $error("half period wrong");
  c_busy: cover property (rd_en && addr == `TWS_ADDR_MODE ##1 rdata[0]);
  c_half: cover property ($fell(sck_out) && cs[4:0] == 5'h02);
  c_rx: cover property (md[7] && !md[6] && sck_oe);
endmodule : tws_port_chk

bind tws_port tws_port_chk i_tws_port_chk (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
  .sck_out, .sck_oe, .so_out);

// [testbench/tws_peer.sv]
// peripheral model at the far end of the serial wires
`timescale 1ns/1ps
module tws_peer (
  input  wire logic       sck,
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic       lsb,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  input  wire logic       so,
  output logic            si,
  output logic [7:0]      rx
);
  int k = 8;
  int j = 8;
  function automatic int pos(input int i);
    return lsb ? i : 7 - i;
  endfunction : pos
  initial si = 1'b0;
  initial rx = 8'h00;
  always @(posedge load)
  begin
    k = 0;
    j = 0;
    if (pha) si = tx[pos(0)];
    if (pha) k = 1;
  end
  // leaving idle is the leading edge; phase zero launches there, phase one samples there
  always @(sck)
    if (j < 8)
    begin
      if ((sck == pol) != pha)
      begin
        if (k < 8) si = tx[pos(k)];
        k++;
      end
      else
      begin
        rx[pos(j)] = so;
        j++;
        if (j == 8) si <= #12 ~si; // released line must not keep its last bit
      end
    end
endmodule : tws_peer

// [testbench/tws_port_tb.sv]
// self-checking bench: register access and byte transfers against a peripheral model
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_port_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        ssi_n_in = 1'b0;
  logic        ext_sck = 1'b1;
  logic [7:0]  rdata;
  logic        sck_out, sck_oe, si_in, so_out;
  logic        pol = 1'b0, pha = 1'b0, lsb = 1'b0, load = 1'b0;
  logic [7:0]  ptx = 8'h00, prx;
  logic [31:0] seed = 32'hF9F7A125;
  logic [7:0]  m_mode = 8'h00, m_csel = 8'h00;
  logic [7:0]  q_sr[$];
  int          fail_count = 0, cmp_count = 0;
  wire         sck = sck_oe ? sck_out : ext_sck; // far master's clock whenever the port does not drive
  always #2.5 clk = ~clk;
  tws_port i_tws_port (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .sck_in(sck), .sck_out,
    .sck_oe, .si_in, .so_out, .ssi_n_in);
  tws_peer i_tws_peer (.sck, .pol, .pha, .lsb, .load, .tx(ptx), .so(so_out), .si(si_in), .rx(prx));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] want(input logic [15:0] a, input logic b);
    if (a == `TWS_ADDR_MODE) return {m_mode[7:4], 3'h0, b};
    if (a == `TWS_ADDR_CSEL) return {3'h0, m_csel[4:0]};
    if (a == `TWS_ADDR_SIO && q_sr.size() > 0) return q_sr.pop_front();
    return 8'h00;
  endfunction : want
  task automatic wrap_up;
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    if (a == `TWS_ADDR_MODE) m_mode = d;
    if (a == `TWS_ADDR_CSEL) m_csel = d;
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd
  task automatic rdc(input logic [15:0] a, input logic b);
    logic [7:0] d;
    rd(a, d);
    chk(d, want(a, b));
  endtask : rdc
  task automatic wait_idle;
    logic [7:0] d;
    for (int n = 0; n < 300; n++)
    begin
      rd(`TWS_ADDR_MODE, d);
      if (d[0] === 1'b0) return;
    end
    fail_count++;
    $display("BAD %0t: busy never cleared", $time);
    wrap_up();
  endtask : wait_idle
  task automatic xfer(input logic [7:0] m, input logic [4:0] c);
    logic [7:0] d;
    ext_sck <= !c[4];
    wr(`TWS_ADDR_MODE, 8'h00);
    wr(`TWS_ADDR_CSEL, {3'h0, c});
    wr(`TWS_ADDR_MODE, m);
    seed = lfsr(seed);
    {pol, pha, lsb, ptx} <= {c[4:3], m[4], seed[15:8]};
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    q_sr.push_back(seed[15:8]);
    if (m[6]) wr(`TWS_ADDR_TXB, seed[7:0]);
    else rd(`TWS_ADDR_SIO, d);
    rdc(`TWS_ADDR_MODE, 1'b1);
    // far master: 16 clock edges 8 cycles apart, clock still outside the byte
    if (c[2:0] == `TWS_CKS_EXT)
      for (int n = 0; n < 16; n++)
      begin
        repeat (8) @(posedge clk);
        ext_sck <= ~ext_sck;
      end
    wait_idle();
    chk(prx, m[6] ? seed[7:0] : 8'h00);
    rdc(`TWS_ADDR_SIO, 1'b0);
  endtask : xfer
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({5'h00, sck_out, sck_oe, so_out}, 8'h04);
    rdc(`TWS_ADDR_MODE, 1'b0);
    rdc(`TWS_ADDR_CSEL, 1'b0);
    wr(16'hFF8C, 8'hFF);
    rdc(16'hFF8C, 1'b0);
    wr(`TWS_ADDR_CSEL, 8'hFF);
    rdc(`TWS_ADDR_CSEL, 1'b0);
    wr(`TWS_ADDR_MODE, 8'h7F);
    rdc(`TWS_ADDR_MODE, 1'b0);
    for (int i = 0; i < 8; i++)
      xfer({3'h6, i[2], 4'h0}, {i[1:0], 3'h2 + {2'h0, i[1] ^ i[2]}});
    xfer(8'h80, 5'h03);
    ssi_n_in <= 1'b1;
    wr(`TWS_ADDR_MODE, 8'h00);
    wr(`TWS_ADDR_CSEL, 8'h02);
    wr(`TWS_ADDR_MODE, 8'hE0);
    wr(`TWS_ADDR_TXB, 8'h3C);
    rdc(`TWS_ADDR_MODE, 1'b0);
    ssi_n_in <= 1'b0;
    xfer(8'hE0, 5'h02);
    xfer(8'hF0, 5'h0F);
    xfer(8'hC0, 5'h17);
    wr(`TWS_ADDR_MODE, 8'h00);
    wr(`TWS_ADDR_CSEL, 8'h06);
    wr(`TWS_ADDR_MODE, 8'hC0);
    wr(`TWS_ADDR_TXB, 8'h5A);
    repeat (20) @(posedge clk);
    rdc(`TWS_ADDR_MODE, 1'b1);
    wr(`TWS_ADDR_MODE, 8'h00);
    rdc(`TWS_ADDR_MODE, 1'b0);
    rdc(`TWS_ADDR_SIO, 1'b0);
    wrap_up();
  end
endmodule : tws_port_tb
